// ==== hdl/gioc_clk_edge.sv ====
`timescale 1ns/1ns
// turns a sampled path clock into rise and fall pulses
module gioc_clk_edge (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_level,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic prev; // level seen at the previous edge
    } gioc_edge_state_t;

    gioc_edge_state_t s;
    gioc_edge_state_t next_s;

    // next state is just the current level
    always_comb begin
        next_s = s;
        next_s.prev = clk_level;
    end

    // pulses are combinational so the owner sees them without lag
    assign rise = clk_level & ~s.prev;
    assign fall = ~clk_level & s.prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

// ==== hdl/gioc_io_cell.sv ====
`timescale 1ns/1ns
// one general-purpose pin: core paths, pad paths and ahb-lite control
module gioc_io_cell (
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core side
    input wire logic [1:0] core_out,
    input wire logic core_oe,
    input wire logic input_path_clock,
    input wire logic output_path_clock,
    output logic [1:0] core_in,
    // device state
    input wire logic configuring,
    input wire logic diff_pair_resource,
    // alternate function, deliberately unregistered
    output logic alternate_input,
    output logic global_clock_net,
    output logic global_control_net,
    output logic pll_reference_input,
    output logic camera_link_clock_input,
    // pad
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pull_up,
    output logic pad_pull_down
);

    ////////////////////////////////////////////////////////////////////////
    // state of the cell, registered as one word

    typedef struct packed {
        logic [15:0] ctrl; // software configuration
        logic [31:0] rdata; // read data for the data phase
        logic wr_pend; // a write data phase is due
        logic wr_ctrl; // that write targets the control word
        logic [1:0] cin; // pad-to-core data
        logic in_fall_q; // falling sample awaiting resync
        logic out_q; // single-edge output register
        logic out_rise_q; // dual-edge output, rising half
        logic out_fall_q; // dual-edge output, falling half
        logic oe_q; // output-enable register
        logic pad_o; // level driven to the pad
        logic pad_e; // pad driver enable
    } gioc_cell_state_t;

    gioc_cell_state_t s;
    gioc_cell_state_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // path clock edges and decoded configuration

    logic in_rise; // input path clock rose
    logic in_fall; // input path clock fell
    logic out_rise; // output path clock rose
    logic out_fall; // output path clock fell
    logic in_ev; // chosen edge of the input register
    logic out_ev; // chosen edge of the output register
    logic oe_ev; // chosen edge of the enable register
    logic in_path; // input path enabled by the mode
    logic out_path; // output path enabled by the mode
    logic oe_path; // enable path taken from the core
    logic clk_path; // clock forwarding enabled
    logic dual; // dual-edge really in force
    logic out_val; // output value before inversion
    logic oe_val; // enable value of the bidirectional mode
    logic ahb_go; // address phase accepted this edge
    logic [11:0] addr; // word-aligned byte address inside the window
    logic [31:0] rd_word; // word returned by a read
    logic [15:0] ctrl_now; // control word with a pending write applied
    logic [31:0] status_word; // live status fields

    gioc_clk_edge u_in_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_level(input_path_clock),
        .rise(in_rise),
        .fall(in_fall)
    );

    gioc_clk_edge u_out_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_level(output_path_clock),
        .rise(out_rise),
        .fall(out_fall)
    );

    // the pull block sees the registered enable, so it follows the pad
    gioc_pad_pull u_pull (
        .hclk(hclk),
        .hresetn(hresetn),
        .configuring(configuring),
        .diff_pair_resource(diff_pair_resource),
        .driving(s.pad_e),
        .pull_down_sel(s.ctrl[gioc_pkg::GIOC_F_PULL_DOWN]),
        .pull_up(pad_pull_up),
        .pull_down(pad_pull_down)
    );

    ////////////////////////////////////////////////////////////////////////
    // mode decode

    // each mode opens only the paths it owns
    always_comb begin
        in_path = 1'b0;
        out_path = 1'b0;
        oe_path = 1'b0;
        clk_path = 1'b0;
        case (gioc_pkg::gioc_mode_t'(s.ctrl[gioc_pkg::GIOC_F_MODE +: 3]))
            gioc_pkg::GIOC_MODE_INPUT: begin
                in_path = 1'b1;
            end
            gioc_pkg::GIOC_MODE_OUTPUT: begin
                out_path = 1'b1;
            end
            gioc_pkg::GIOC_MODE_BIDIR: begin
                in_path = 1'b1;
                out_path = 1'b1;
                oe_path = 1'b1;
            end
            gioc_pkg::GIOC_MODE_CLKOUT: begin
                clk_path = 1'b1;
            end
            default: begin
                // unused and undefined codes leave the pad released
                in_path = 1'b0;
            end
        endcase
    end

    // diff-pair pins never get the dual-edge registers
    assign dual = s.ctrl[gioc_pkg::GIOC_F_DUAL] &
        ~diff_pair_resource;

    // every register picks its own edge
    assign in_ev = s.ctrl[gioc_pkg::GIOC_F_IN_FALL] ?
        in_fall : in_rise;
    assign out_ev = s.ctrl[gioc_pkg::GIOC_F_OUT_FALL] ?
        out_fall : out_rise;
    assign oe_ev = s.ctrl[gioc_pkg::GIOC_F_OE_FALL] ?
        out_fall : out_rise;

    ////////////////////////////////////////////////////////////////////////
    // bus decode and read mux

    assign ahb_go = hsel & htrans[1] & hready;
    assign addr = {haddr[gioc_pkg::GIOC_ADDR_W-1:2], 2'b00};

    // a read right behind a write must see the new control word
    assign ctrl_now = (s.wr_pend & s.wr_ctrl) ?
        hwdata[gioc_pkg::GIOC_CTRL_W-1:0] : s.ctrl;

    // status shows what the cell is doing now
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[gioc_pkg::GIOC_S_CORE_IN +: 2] = s.cin;
        status_word[gioc_pkg::GIOC_S_PAD] = pad_in;
        status_word[gioc_pkg::GIOC_S_OE] = s.pad_e;
        status_word[gioc_pkg::GIOC_S_CONFIG] = configuring;
        status_word[gioc_pkg::GIOC_S_DIFF] = diff_pair_resource;
        status_word[gioc_pkg::GIOC_S_DUAL] = dual;
    end

    // unmapped offsets read as zero and ignore writes
    always_comb begin
        rd_word = 32'h0000_0000;
        if (addr == gioc_pkg::GIOC_CTRL_OFFSET) begin
            rd_word = {16'h0000, ctrl_now};
        end else if (addr == gioc_pkg::GIOC_STATUS_OFFSET) begin
            rd_word = status_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s = s;
        out_val = 1'b0;
        oe_val = 1'b0;

        // bus: writes land one edge after their address phase
        next_s.wr_pend = 1'b0;
        if (s.wr_pend && s.wr_ctrl) begin
            next_s.ctrl = hwdata[gioc_pkg::GIOC_CTRL_W-1:0];
        end
        if (ahb_go) begin
            if (hwrite) begin
                next_s.wr_pend = 1'b1;
                next_s.wr_ctrl = (addr == gioc_pkg::GIOC_CTRL_OFFSET);
            end else begin
                next_s.rdata = rd_word;
            end
        end

        // input path
        if (!in_path) begin
            // disabled path shows zeros to the core
            next_s.cin = 2'b00;
            next_s.in_fall_q = 1'b0;
        end else if (dual) begin
            if (s.ctrl[gioc_pkg::GIOC_F_RESYNC]) begin
                // falling sample waits for the next rising edge
                if (in_fall) begin
                    next_s.in_fall_q = pad_in;
                end
                if (in_rise) begin
                    next_s.cin[0] = pad_in;
                    next_s.cin[1] = s.in_fall_q;
                end
            end else begin
                // both halves go to the core as soon as taken
                if (in_rise) begin
                    next_s.cin[0] = pad_in;
                end
                if (in_fall) begin
                    next_s.cin[1] = pad_in;
                end
            end
        end else if (s.ctrl[gioc_pkg::GIOC_F_IN_REG]) begin
            // registered single-edge input, bit 1 held low
            next_s.cin[1] = 1'b0;
            if (in_ev) begin
                next_s.cin[0] = pad_in;
            end
        end else begin
            // bypassed input, only the hclk sampling stage remains
            next_s.cin = {1'b0, pad_in};
        end

        // output path value
        if (dual) begin
            if (out_rise) begin
                next_s.out_rise_q = core_out[0];
            end
            if (out_fall) begin
                next_s.out_fall_q = core_out[1];
            end
            // high half of the clock shows bit 0, low half bit 1
            out_val = output_path_clock ?
                next_s.out_rise_q : next_s.out_fall_q;
        end else if (s.ctrl[gioc_pkg::GIOC_F_OUT_REG]) begin
            if (out_ev) begin
                next_s.out_q = core_out[0];
            end
            out_val = next_s.out_q;
        end else begin
            out_val = core_out[0];
        end

        // enable path, registered or bypassed on its own
        if (s.ctrl[gioc_pkg::GIOC_F_OE_REG]) begin
            if (oe_ev) begin
                next_s.oe_q = core_oe;
            end
            oe_val = next_s.oe_q;
        end else begin
            oe_val = core_oe;
        end

        // pad drive; configuration always keeps the driver off
        if (configuring) begin
            next_s.pad_o = 1'b0;
            next_s.pad_e = 1'b0;
        end else if (clk_path) begin
            next_s.pad_o = output_path_clock;
            next_s.pad_e = 1'b1;
        end else if (out_path) begin
            next_s.pad_o = out_val ^ s.ctrl[gioc_pkg::GIOC_F_INVERT];
            // bidir follows the core enable, output mode always drives
            next_s.pad_e = oe_path ? oe_val : 1'b1;
        end else begin
            next_s.pad_o = 1'b0;
            next_s.pad_e = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.ctrl <= gioc_pkg::GIOC_CTRL_RESET;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states, and the slave never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;

    assign core_in = s.cin;
    // a released pad is never driven; the pull block takes over
    assign pad_out = s.pad_o;
    assign pad_oe = s.pad_e;

    // alternate function: pad straight to the chosen network, no flop,
    // so clocks routed this way keep their edges; the price is that
    // these outputs carry pad glitches as they are
    always_comb begin
        alternate_input = 1'b0;
        global_clock_net = 1'b0;
        global_control_net = 1'b0;
        pll_reference_input = 1'b0;
        camera_link_clock_input = 1'b0;
        if (in_path && s.ctrl[gioc_pkg::GIOC_F_ALT_SEL]) begin
            alternate_input = pad_in;
            case (gioc_pkg::gioc_alt_t'(
                    s.ctrl[gioc_pkg::GIOC_F_ALT_ROUTE +: 2]))
                gioc_pkg::GIOC_ALT_GLOBAL_CLOCK_NET: begin
                    global_clock_net = pad_in;
                end
                gioc_pkg::GIOC_ALT_GLOBAL_CONTROL_NET: begin
                    global_control_net = pad_in;
                end
                gioc_pkg::GIOC_ALT_PLL: begin
                    pll_reference_input = pad_in;
                end
                gioc_pkg::GIOC_ALT_CAMERA: begin
                    camera_link_clock_input = pad_in;
                end
                default: begin
                    global_clock_net = 1'b0;
                end
            endcase
        end
    end

endmodule

// ==== hdl/gioc_pad_pull.sv ====
`timescale 1ns/1ns
// chooses the weak pull resistor of the pad
module gioc_pad_pull (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic configuring,
    input wire logic diff_pair_resource,
    input wire logic driving,
    input wire logic pull_down_sel,
    output logic pull_up,
    output logic pull_down
);

    typedef struct packed {
        logic up;
        logic down;
    } gioc_pull_state_t;

    gioc_pull_state_t s;
    gioc_pull_state_t next_s;
    logic down_ok; // pull-down really available on this pin

    // configuration wins, then an active driver, then the chosen pull
    always_comb begin
        next_s = s;
        down_ok = pull_down_sel & ~diff_pair_resource;
        if (configuring) begin
            // diff-pair pins are left alone during configuration
            next_s.up = ~diff_pair_resource;
            next_s.down = 1'b0;
        end else if (driving) begin
            // no pull fights the driver
            next_s.up = 1'b0;
            next_s.down = 1'b0;
        end else begin
            // released or unused pad keeps its weak pull
            next_s.up = ~down_ok;
            next_s.down = down_ok;
        end
    end

    assign pull_up = s.up;
    assign pull_down = s.down;

    // reset state matches the configuration default of pull-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s.up <= gioc_pkg::GIOC_PULL_UP_RESET;
            s.down <= gioc_pkg::GIOC_PULL_DOWN_RESET;
        end else begin
            s <= next_s;
        end
    end

endmodule

// ==== include/gioc_pkg.sv ====
package gioc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte offsets inside a 4 KB window
    localparam int GIOC_ADDR_W = 12;
    localparam logic [11:0] GIOC_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] GIOC_STATUS_OFFSET = 12'h004;

    ////////////////////////////////////////////////////////////////////////
    // control register field positions
    localparam int GIOC_F_MODE = 0; // three bits
    localparam int GIOC_F_IN_REG = 3;
    localparam int GIOC_F_OUT_REG = 4;
    localparam int GIOC_F_OE_REG = 5;
    localparam int GIOC_F_IN_FALL = 6;
    localparam int GIOC_F_OUT_FALL = 7;
    localparam int GIOC_F_OE_FALL = 8;
    localparam int GIOC_F_INVERT = 9;
    localparam int GIOC_F_DUAL = 10;
    localparam int GIOC_F_RESYNC = 11;
    localparam int GIOC_F_ALT_SEL = 12;
    localparam int GIOC_F_ALT_ROUTE = 13; // two bits
    localparam int GIOC_F_PULL_DOWN = 15;
    localparam int GIOC_CTRL_W = 16;
    localparam logic [15:0] GIOC_CTRL_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // status register field positions
    localparam int GIOC_S_CORE_IN = 0; // two bits
    localparam int GIOC_S_PAD = 2;
    localparam int GIOC_S_OE = 3;
    localparam int GIOC_S_CONFIG = 4;
    localparam int GIOC_S_DIFF = 5;
    localparam int GIOC_S_DUAL = 6;

    ////////////////////////////////////////////////////////////////////////
    // reset values of the pad-facing flops
    localparam logic GIOC_PULL_UP_RESET = 1'b1;
    localparam logic GIOC_PULL_DOWN_RESET = 1'b0;

    // operating modes of the cell
    typedef enum logic [2:0] {
        GIOC_MODE_UNUSED,
        GIOC_MODE_INPUT,
        GIOC_MODE_OUTPUT,
        GIOC_MODE_BIDIR,
        GIOC_MODE_CLKOUT
    } gioc_mode_t;

    // destinations of the alternate input
    typedef enum logic [1:0] {
        GIOC_ALT_GLOBAL_CLOCK_NET,
        GIOC_ALT_GLOBAL_CONTROL_NET,
        GIOC_ALT_PLL,
        GIOC_ALT_CAMERA
    } gioc_alt_t;

endpackage

// ==== verif/gioc_io_cell_monitor.sv ====
`timescale 1ns/1ns
// port-level checks of the pin cell; ctrl is shadowed from bus writes
module gioc_io_cell_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [1:0] core_out,
    input wire logic core_oe,
    input wire logic input_path_clock,
    input wire logic output_path_clock,
    input wire logic [1:0] core_in,
    input wire logic configuring,
    input wire logic diff_pair_resource,
    input wire logic alternate_input,
    input wire logic global_clock_net,
    input wire logic global_control_net,
    input wire logic pll_reference_input,
    input wire logic camera_link_clock_input,
    input wire logic pad_in,
    input wire logic pad_out,
    input wire logic pad_oe,
    input wire logic pad_pull_up,
    input wire logic pad_pull_down
);
    ////////////////////////////////////////
    logic [15:0] ctrl; // lands at the same edge as the design's copy
    logic wr_pend; // control write is in its data phase
    logic ipc_q, opc_q; // path clocks one edge back, for edge detection
    // shadow register and sampled path clocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= gioc_pkg::GIOC_CTRL_RESET;
            wr_pend <= 1'b0;
            ipc_q <= 1'b0;
            opc_q <= 1'b0;
        end else begin
            ipc_q <= input_path_clock;
            opc_q <= output_path_clock;
            if (hready) begin
                wr_pend <= hsel && htrans[1] && hwrite &&
                    haddr[11:0] == gioc_pkg::GIOC_CTRL_OFFSET;
            end
            if (wr_pend && hready) ctrl <= hwdata[15:0];
        end
    end
    wire [2:0] mode = ctrl[2:0];
    wire in_on = mode == 3'h1 || mode == 3'h3;
    wire dual = ctrl[10] && !diff_pair_resource; // diff pins lose it
    wire alt_on = in_on && ctrl[12];
    wire reg_in = in_on && ctrl[3] && !dual;
    wire dual_in = in_on && ctrl[3] && dual && !ctrl[11];
    wire dual_out = mode == 3'h2 && ctrl[4] && dual && !configuring;
    wire i_rise = input_path_clock && !ipc_q;
    wire i_fall = !input_path_clock && ipc_q;
    wire o_rise = output_path_clock && !opc_q;
    wire o_fall = !output_path_clock && opc_q;
    wire in_edge = ctrl[6] ? i_fall : i_rise;
    ////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    chk_config_pullup: assert property (
        (configuring && !diff_pair_resource)[*3] |->
        pad_pull_up && !pad_pull_down && !pad_oe)
        else $error("configuring pin not weakly pulled up");
    chk_release_pull: assert property (
        (!pad_oe && !configuring)[*2] |-> pad_pull_up == !pad_pull_down
        && pad_pull_down == $past(ctrl[15] && !diff_pair_resource))
        else $error("released pad has wrong weak pull");
    chk_drive_nopull: assert property (pad_oe[*2] |->
        !pad_pull_up && !pad_pull_down)
        else $error("pull left on while driving");
    chk_diff_nodown: assert property (diff_pair_resource[*2] |->
        !pad_pull_down) else $error("diff pin has pull-down");
    chk_alt_route: assert property (
        alternate_input == (alt_on && pad_in)
        && {camera_link_clock_input, pll_reference_input,
        global_control_net, global_clock_net} ==
        ({3'h0, alt_on && pad_in} << ctrl[14:13]))
        else $error("alternate input not passed straight");
    chk_bypass_in: assert property (
        in_on && !ctrl[3] && !dual |=> core_in == {1'b0, $past(pad_in)})
        else $error("bypassed input wrong");
    chk_reg_in: assert property (reg_in && $past(reg_in) |=>
        core_in == ($past(in_edge) ? {1'b0, $past(pad_in)} : $past(core_in)))
        else $error("registered input wrong");
    chk_dual_in: assert property (
        dual_in && $past(dual_in) |=> core_in == {$past(i_fall) ?
        $past(pad_in) : $past(core_in[1]),
        $past(i_rise) ? $past(pad_in) : $past(core_in[0])})
        else $error("dual-edge input wrong");
    chk_out_bypass: assert property (
        (mode == 3'h2 || mode == 3'h3) && !ctrl[4] && !ctrl[5]
        && !dual && !configuring |=>
        pad_out == $past(core_out[0] ^ ctrl[9])
        && pad_oe == $past(mode == 3'h2 || core_oe))
        else $error("bypassed output or enable wrong");
    chk_dual_out: assert property (dual_out && $past(dual_out)
        && $stable(ctrl[9]) |=>
        pad_out == ($past(o_rise) ? $past(core_out[0] ^ ctrl[9]) :
        $past(o_fall) ? $past(core_out[1] ^ ctrl[9]) : $past(pad_out)))
        else $error("dual-edge output wrong");
    chk_clock_out: assert property (mode == 3'h4 && !ctrl[5] &&
        !configuring |=> pad_oe && pad_out == $past(output_path_clock))
        else $error("clock not forwarded");
    chk_unused_pin: assert property (!in_on |=> core_in == 2'h0 &&
        !(pad_oe && $past(mode == 3'h0)))
        else $error("unused or output-only pin misbehaves");
    cover property (dual_in && i_fall);
    cover property (alt_on && pad_in);
    cover property (dual_out && o_fall);
    cover property (mode == 3'h4 && o_rise);
endmodule
bind gioc_io_cell gioc_io_cell_monitor gioc_io_cell_monitor_i (.*);

// ==== verif/gioc_pad_model.sv ====
`timescale 1ns/1ns
// pad seen from outside: cell driver, far-side driver, weak pulls
module gioc_pad_model (
    input wire logic hclk,
    input wire logic pad_out,
    input wire logic pad_oe,
    input wire logic pad_pull_up,
    input wire logic pad_pull_down,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pad_in
);
    logic toggle = 1'b0; // a floating pad must not look stable
    // free-running pattern for a pad nobody holds
    always @(posedge hclk) begin
        toggle <= !toggle;
    end
    // the cell wins, then the far side, then the weak pull
    always_comb begin
        if (pad_oe) begin
            pad_in = pad_out;
        end else if (ext_en) begin
            pad_in = ext_val; // far side only drives a released pad
        end else if (pad_pull_up) begin
            pad_in = 1'b1;
        end else if (pad_pull_down) begin
            pad_in = 1'b0;
        end else begin
            pad_in = toggle;
        end
    end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("FAIL %s exp %h got %h", nm, e, g); \
    end \
end
// bench: ahb master, core and pad stimulus, read scoreboard
module testbench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, r2, exp_v;
    logic [1:0] htrans = 2'h0, core_out = 2'h0, core_in;
    logic [2:0] hsize = 3'h2; // word transfers only
    logic hready, hreadyout, hresp, core_oe = 1'b0;
    logic input_path_clock = 1'b0, output_path_clock = 1'b0;
    logic configuring = 1'b0, diff_pair_resource = 1'b0;
    logic alternate_input, global_clock_net, global_control_net;
    logic pll_reference_input, camera_link_clock_input;
    logic pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
    logic ext_en = 1'b0, ext_val = 1'b0, run = 1'b0, rd_phase = 1'b0;
    logic [31:0] seed = 32'h4b92b251, exp_q[$]; // reads expected, oldest first
    int num_errors = 0, compares = 0, cycles = 0, dwell = 0;
    localparam logic [31:0] A_CTRL = 32'(gioc_pkg::GIOC_CTRL_OFFSET);
    localparam logic [31:0] A_STAT = 32'(gioc_pkg::GIOC_STATUS_OFFSET);
    assign hready = hreadyout; // single slave drives the bus ready
    gioc_io_cell gioc_io_cell_i (.*);
    gioc_pad_model gioc_pad_model_i (.*);
    always #2 hclk = !hclk;
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic conclude();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one word transfer; a read notes its expected word in the queue
    task automatic ahb(input logic wr, input logic [31:0] a,
            input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        if (wr) hwdata <= d;
        else exp_q.push_back(d);
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask
    // path clock level and pad value, settle, then read status back
    task automatic step(input logic lvl, input logic v,
            input logic [1:0] ci, input logic [1:0] dd);
        input_path_clock <= lvl;
        ext_val <= v;
        repeat (3) @(posedge hclk);
        ahb(1'b0, A_STAT, {25'h0, dd, 2'h0, v, ci});
    endtask
    // a hang counts as a mismatch
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // scoreboard: a read data phase ends, compare with the oldest note
    always @(posedge hclk) begin
        if (rd_phase && hready === 1'b1) begin
            exp_v = exp_q.pop_front();
            `CHK("hrdata", exp_v, hrdata)
        end
        if (hready === 1'b1) rd_phase <= hsel && htrans[1] && !hwrite;
    end
    // random core data, far-side pad and path clocks held >= 2 cycles
    always @(posedge hclk) begin
        if (run) begin
            r = rnd();
            core_out <= r[1:0];
            core_oe <= r[2];
            ext_en <= r[3];
            ext_val <= r[4];
            if (dwell == 0) begin
                input_path_clock <= input_path_clock ^ r[5];
                output_path_clock <= output_path_clock ^ r[6];
                dwell = 1 + int'(r[8:7]);
            end else dwell--;
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge hclk);
        `CHK("pad_pull_up", 1'b1, pad_pull_up)
        `CHK("pad_oe", 1'b0, pad_oe)
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, A_CTRL, 32'h0);
        ahb(1'b1, 32'h8, 32'hffffffff); // unmapped, ignored
        ahb(1'b1, A_STAT, 32'hffffffff); // read-only, ignored
        ahb(1'b0, 32'h8, 32'h0);
        ahb(1'b0, A_STAT, 32'h4); // released pad pulled up
        // configuring overrides an output pin
        ahb(1'b1, A_CTRL, 32'h2);
        configuring <= 1'b1;
        repeat (4) @(posedge hclk);
        ahb(1'b0, A_STAT, 32'h14);
        configuring <= 1'b0;
        repeat (4) @(posedge hclk);
        ahb(1'b0, A_STAT, 32'h8);
        // dual-edge input, resync then plain, then on a diff pin
        ext_en <= 1'b1;
        ahb(1'b1, A_CTRL, 32'h0c09);
        step(1'b1, 1'b0, 2'h0, 2'h2);
        step(1'b0, 1'b1, 2'h0, 2'h2);
        step(1'b1, 1'b0, 2'h2, 2'h2);
        step(1'b0, 1'b0, 2'h2, 2'h2);
        step(1'b1, 1'b1, 2'h1, 2'h2);
        ahb(1'b1, A_CTRL, 32'h0409);
        step(1'b0, 1'b1, 2'h3, 2'h2);
        step(1'b1, 1'b0, 2'h2, 2'h2);
        diff_pair_resource <= 1'b1;
        step(1'b0, 1'b0, 2'h0, 2'h1);
        step(1'b1, 1'b1, 2'h1, 2'h1);
        // random configurations; the monitor judges the pins
        run <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            r2 = rnd();
            configuring <= r2[31:28] == 4'h0;
            diff_pair_resource <= r2[27:24] == 4'h0;
            ahb(1'b1, A_CTRL, r2);
            ahb(1'b0, A_CTRL, {16'h0, r2[15:0]}); // upper bits read 0
            repeat (40) @(posedge hclk);
        end
        conclude();
    end
endmodule
